// ### src/host_port_pkg.sv
// Shared constants and types for the host port pin control block
package host_port_pkg;

	localparam int SYNC_STAGES = 2;

	// Host control pins, pin levels as seen on the board
	typedef struct packed {
		logic       cs_n;
		logic       ds1_n;
		logic       ds2_n;
		logic       as_n;
		logic       read_write;
		logic       byte_ident;
		logic [1:0] ctrl;
	} host_ctl_s;

	// Test and emulation pins that form the global output-disable condition
	typedef struct packed {
		logic test_reset;
		logic emulation_pin0;
		logic emulation_pin1_disable;
	} test_cond_s;

	// Everything sampled from pins through the shared synchroniser; the strap has its own
	typedef struct packed {
		host_ctl_s  ctl;
		logic [7:0] data;
		test_cond_s tst;
	} host_pins_s;

	localparam int PINS_WIDTH = $bits(host_pins_s);

	// One decoded host access handed to the internal logic
	typedef struct packed {
		logic       write;
		logic       byte_ident;
		logic [1:0] ctrl;
	} host_access_s;

	// Pad controls: pullups, bus holders, strap pulldown
	typedef struct packed {
		logic pullup_en;
		logic data_hold_en;
		logic strap_pulldown_en;
	} pad_ctl_s;

	typedef enum logic [1:0] {
		ST_IN_RESET   = 2'h0,
		ST_SELECTED   = 2'h1,
		ST_DESELECTED = 2'h2
	} port_state_e;

	localparam host_ctl_s    CTL_IDLE     = '{cs_n: 1'h1, ds1_n: 1'h1, ds2_n: 1'h1, as_n: 1'h1,
		read_write: 1'h1, byte_ident: 1'h0, ctrl: 2'h0};
	localparam test_cond_s   TEST_IDLE    = '{test_reset: 1'h1, emulation_pin0: 1'h0,
		emulation_pin1_disable: 1'h1};
	localparam logic [7:0]   DATA_RESET   = 8'h00;
	localparam host_pins_s   PINS_RESET   = '{ctl: CTL_IDLE, data: DATA_RESET, tst: TEST_IDLE};
	localparam host_access_s ACCESS_RESET = '{write: 1'h0, byte_ident: 1'h0, ctrl: 2'h0};
	localparam pad_ctl_s     PADS_RESET   = '{pullup_en: 1'h0, data_hold_en: 1'h0,
		strap_pulldown_en: 1'h1};
	localparam logic         INTR_N_RESET = 1'h1;

endpackage

// ### src/pin_sync.sv
// Two-flop synchroniser for pin inputs, optional asynchronous reset
`timescale 1ns/10ps
module pin_sync #(
	parameter int               WIDTH       = 1,
	parameter bit               RESET_EN    = 1'b1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             CLK,
	input  wire logic             ARST_N,
	input  wire logic [WIDTH-1:0] PIN,
	output logic      [WIDTH-1:0] SYNCED
);
	import host_port_pkg::*;

	logic [SYNC_STAGES-1:0][WIDTH-1:0] stage;
	logic [SYNC_STAGES-1:0][WIDTH-1:0] next_stage;

	always_comb begin
		next_stage    = stage;
		next_stage[0] = PIN;
		for (int i = 1; i < SYNC_STAGES; i++) begin
			next_stage[i] = stage[i-1];
		end
	end

	// A strap sync runs through reset so its value is ready at release
	generate
		if (RESET_EN) begin : g_rst
			always_ff @(posedge CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					stage <= {SYNC_STAGES{RESET_VALUE}};
				end else begin
					stage <= next_stage;
				end
			end
		end else begin : g_free
			always_ff @(posedge CLK) begin
				stage <= next_stage;
			end
		end
	endgenerate

	assign SYNCED = stage[SYNC_STAGES-1];

endmodule

// ### src/host_port_pin_control.sv
// Pin-level control of the parallel host port: strap, pads, output drivers
//
// Contract
// - Ready pin floats under global output disable
// - Interrupt pin driven high during reset
// - Interrupt pin floats under global output disable
// - Strap low or open: port deselected, silent but for the ready pin, still driven from CORE_READY
// - Deselected: input pullups on, data holders on
// - Strap sampled at reset release, then ignored
// - Strap pulldown active only while in reset
// - Data bus floats unless driving read data
// - Software enables holders keeping last bus level
// - Disable: test low, emulation pin0 high, off low
`timescale 1ns/10ps
module host_port_pin_control (
	input  wire logic                        CLK,
	input  wire logic                        ARST_N,
	// Host pins
	input  wire host_port_pkg::host_ctl_s    HOST_CTL,
	input  wire logic [7:0]                  HOST_DATA_I,
	output logic      [7:0]                  HOST_DATA_O,
	output logic                             HOST_DATA_OE_N,
	output logic                             HOST_READY,
	output logic                             HOST_READY_OE_N,
	output logic                             HOST_INTERRUPT_N,
	output logic                             HOST_INTERRUPT_OE_N,
	input  wire logic                        HOST_PORT_ENABLE_STRAP,
	output host_port_pkg::pad_ctl_s          PADS,
	// Test and emulation pins
	input  wire host_port_pkg::test_cond_s   TEST_PINS,
	output logic                             OUTPUTS_OFF,
	// Internal side
	input  wire logic                        CORE_READY,
	input  wire logic                        CORE_INTERRUPT,
	input  wire logic                        CORE_RD_EN,
	input  wire logic [7:0]                  CORE_RD_DATA,
	input  wire logic                        HOLDER_SW_EN,
	output logic                             PORT_SELECTED,
	output logic                             ACCESS_STB,
	output host_port_pkg::host_access_s      ACCESS,
	output logic      [7:0]                  WR_DATA
);
	import host_port_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		port_state_e  state;
		logic         strobe_prev;
		logic         access_stb;
		host_access_s access;
		logic [7:0]   wr_data;
		logic [7:0]   rd_data;
		logic         rd_drive;
		logic         ready;
		logic         ready_off;
		logic         intr_n;
		logic         intr_off;
		logic         off;
		pad_ctl_s     pads;
	} ctl_state_s;

	localparam ctl_state_s STATE_RESET = '{
		state:       ST_IN_RESET,
		strobe_prev: 1'h0,
		access_stb:  1'h0,
		access:      ACCESS_RESET,
		wr_data:     DATA_RESET,
		rd_data:     DATA_RESET,
		rd_drive:    1'h0,
		ready:       1'h0,
		ready_off:   1'h0,
		intr_n:      INTR_N_RESET,
		intr_off:    1'h0,
		off:         1'h0,
		pads:        PADS_RESET
	};

	ctl_state_s cur;
	ctl_state_s next_cur;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	host_pins_s pins_raw;
	host_pins_s pins;
	logic       strap;

	assign pins_raw = '{ctl: HOST_CTL, data: HOST_DATA_I, tst: TEST_PINS};

	pin_sync #(
		.WIDTH       (PINS_WIDTH),
		.RESET_EN    (1'b1),
		.RESET_VALUE (PINS_RESET)
	) u_pins_sync (
		.CLK    (CLK),
		.ARST_N (ARST_N),
		.PIN    (pins_raw),
		.SYNCED (pins)
	);

	// Not reset: tracks the pulled-down strap during reset
	pin_sync #(
		.WIDTH       (1),
		.RESET_EN    (1'b0),
		.RESET_VALUE (1'h0)
	) u_strap_sync (
		.CLK    (CLK),
		.ARST_N (ARST_N),
		.PIN    (HOST_PORT_ENABLE_STRAP),
		.SYNCED (strap)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decoding

	function automatic logic output_disable(input test_cond_s t);
		output_disable = !t.test_reset && t.emulation_pin0 && !t.emulation_pin1_disable;
	endfunction

	function automatic logic strobe_active(input host_ctl_s c);
		strobe_active = !c.cs_n && (c.ds1_n != c.ds2_n);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	logic      selected;
	logic      deselected;
	logic      off;
	host_ctl_s ctl_gated;
	logic      strobe_now;

	always_comb begin
		next_cur   = cur;
		selected   = (cur.state == ST_SELECTED);
		deselected = (cur.state == ST_DESELECTED);
		off        = output_disable(pins.tst);
		// Deselected port sees idle pins, so no access can start
		ctl_gated  = selected ? pins.ctl : CTL_IDLE;
		strobe_now = strobe_active(ctl_gated);

		case (cur.state)
			ST_IN_RESET: begin
				next_cur.state = strap ? ST_SELECTED : ST_DESELECTED;
			end
			ST_SELECTED: begin
				next_cur.state = ST_SELECTED;
			end
			ST_DESELECTED: begin
				next_cur.state = ST_DESELECTED;
			end
			default: begin
				next_cur.state = ST_IN_RESET;
			end
		endcase

		// Access pulse on strobe start, fields caught at the same edge
		next_cur.strobe_prev = strobe_now;
		next_cur.access_stb  = strobe_now && !cur.strobe_prev;
		if (strobe_now && !cur.strobe_prev) begin
			next_cur.access.write      = !ctl_gated.read_write;
			next_cur.access.byte_ident = ctl_gated.byte_ident;
			next_cur.access.ctrl       = ctl_gated.ctrl;
			next_cur.wr_data           = pins.data;
		end

		if (CORE_RD_EN) begin
			next_cur.rd_data = CORE_RD_DATA;
		end
		// Bus floats when deselected, disabled or idle
		next_cur.rd_drive = selected && CORE_RD_EN && !off;

		// Drivers switch together from the synced disable
		next_cur.off       = off;
		next_cur.ready     = CORE_READY;
		next_cur.ready_off = off;
		// Deselected port keeps the interrupt pin inactive
		next_cur.intr_n    = selected ? !CORE_INTERRUPT : 1'h1;
		next_cur.intr_off  = off;

		// Pulldown dropped at the first edge after release
		next_cur.pads.strap_pulldown_en = 1'h0;
		next_cur.pads.pullup_en         = (next_cur.state == ST_DESELECTED);
		next_cur.pads.data_hold_en      = (next_cur.state == ST_DESELECTED)
			|| HOLDER_SW_EN;
		if (deselected) begin
			next_cur.pads.pullup_en    = 1'h1;
			next_cur.pads.data_hold_en = 1'h1;
		end
	end

	// Reset value drives the interrupt pin high and enables the pulldown
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cur <= STATE_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign HOST_DATA_O         = cur.rd_data;
	assign HOST_DATA_OE_N      = !cur.rd_drive;
	assign HOST_READY          = cur.ready;
	assign HOST_READY_OE_N     = cur.ready_off;
	assign HOST_INTERRUPT_N    = cur.intr_n;
	assign HOST_INTERRUPT_OE_N = cur.intr_off;
	assign PADS                = cur.pads;
	assign OUTPUTS_OFF         = cur.off;
	assign PORT_SELECTED       = (cur.state == ST_SELECTED);
	assign ACCESS_STB          = cur.access_stb;
	assign ACCESS              = cur.access;
	assign WR_DATA             = cur.wr_data;

endmodule

// ### bench/host_port_checker.sv
// Assertions on the host port pin control ports
`timescale 1ns/10ps
module host_port_checker (
	input wire logic                      CLK,
	input wire logic                      ARST_N,
	input wire host_port_pkg::host_ctl_s  HOST_CTL,
	input wire logic [7:0]                HOST_DATA_O,
	input wire logic                      HOST_DATA_OE_N,
	input wire logic                      HOST_READY_OE_N,
	input wire logic                      HOST_INTERRUPT_N,
	input wire logic                      HOST_INTERRUPT_OE_N,
	input wire host_port_pkg::pad_ctl_s   PADS,
	input wire host_port_pkg::test_cond_s TEST_PINS,
	input wire logic                      OUTPUTS_OFF,
	input wire logic                      CORE_RD_EN,
	input wire logic [7:0]                CORE_RD_DATA,
	input wire logic                      PORT_SELECTED,
	input wire logic                      ACCESS_STB
);
	import host_port_pkg::*;
	logic strobe;
	logic off_pins;
	assign strobe = !HOST_CTL.cs_n && (HOST_CTL.ds1_n != HOST_CTL.ds2_n);
	assign off_pins = !TEST_PINS.test_reset && TEST_PINS.emulation_pin0 && !TEST_PINS.emulation_pin1_disable;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	sequence stb_start;
		PORT_SELECTED && $rose(strobe);
	endsequence
	sequence stb_pulse;
		ACCESS_STB ##1 !ACCESS_STB;
	endsequence
	////////////////////////////////////////////////////////////////
	chk_ready_float: assert property (OUTPUTS_OFF |-> HOST_READY_OE_N)
		else $error("ready pin driven while outputs off");
	chk_intr_float: assert property (OUTPUTS_OFF |-> HOST_INTERRUPT_OE_N)
		else $error("interrupt pin driven while outputs off");
	chk_off_set: assert property (off_pins [*4] |-> OUTPUTS_OFF && HOST_DATA_OE_N)
		else $error("output disable not applied");
	chk_reset_drive: assert property (disable iff (1'b0)
		!ARST_N |-> HOST_INTERRUPT_N && !HOST_INTERRUPT_OE_N && PADS.strap_pulldown_en)
		else $error("reset drive levels wrong");
	chk_pd_release: assert property (ARST_N && $past(ARST_N) |-> !PADS.strap_pulldown_en)
		else $error("strap pulldown kept after reset");
	chk_desel_pads: assert property (ARST_N && $past(ARST_N) && !PORT_SELECTED
		|-> PADS.pullup_en && PADS.data_hold_en)
		else $error("deselected pads not pulled");
	chk_strap_hold: assert property ($past(ARST_N) && $past(ARST_N, 2)
		|-> $stable(PORT_SELECTED))
		else $error("selection changed after reset");
	chk_read_drive: assert property (PORT_SELECTED && !OUTPUTS_OFF && CORE_RD_EN
		|=> OUTPUTS_OFF || (!HOST_DATA_OE_N && HOST_DATA_O == $past(CORE_RD_DATA)))
		else $error("read data not driven");
	chk_stb_lag: assert property (stb_start |-> ##3 stb_pulse)
		else $error("access pulse late or long");
	chk_desel_quiet: assert property (!PORT_SELECTED |-> !ACCESS_STB)
		else $error("access from deselected port");
endmodule

bind host_port_pin_control host_port_checker i_chk (.*);

// ### bench/host_model.sv
// Behavioural host processor driving the host port pins
`timescale 1ns/10ps
module host_model (
	input wire logic                 CLK,
	output host_port_pkg::host_ctl_s CTL,
	output logic [7:0]               DQ
);
	import host_port_pkg::*;
	initial begin
		CTL = CTL_IDLE;
		DQ = 8'h00;
	end
	task automatic access(input logic wr, input logic bi, input logic [7:0] d);
		@(negedge CLK);
		CTL.cs_n = 1'h0;
		CTL.byte_ident = bi;
		CTL.ds1_n = 1'h0;
		CTL.read_write = !wr;
		CTL.ctrl = 2'h2;
		DQ = d;
		repeat (4) @(negedge CLK);
		CTL = CTL_IDLE;
		// Released bus must not show the old byte
		DQ = ~d;
		@(negedge CLK);
	endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the host port pin control block
`timescale 1ns/10ps
module testbench;
	import host_port_pkg::*;
	logic         clk = 1'h0;
	logic         arst_n = 1'h1;
	logic         strap = 1'h1;
	logic         rd_en = 1'h0;
	logic         hold = 1'h0;
	logic         core_int = 1'h0;
	logic         core_rdy = 1'h0;
	test_cond_s   tst = TEST_IDLE;
	host_ctl_s    ctl;
	pad_ctl_s     pads;
	host_access_s acc;
	logic [7:0]   dq_i, dq_o, wd;
	logic         dq_oe_n, rdy, rdy_oe_n, int_n, int_oe_n, off, sel, stb;
	int           fails = 0, checks = 0, cyc = 0, pulses = 0;
	// Test pins beside the expected disable flag
	logic [3:0]   rows [8] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};

	host_port_pin_control i_dut (
		.CLK(clk), .ARST_N(arst_n), .HOST_CTL(ctl), .HOST_DATA_I(dq_i),
		.HOST_DATA_O(dq_o), .HOST_DATA_OE_N(dq_oe_n), .HOST_READY(rdy),
		.HOST_READY_OE_N(rdy_oe_n), .HOST_INTERRUPT_N(int_n),
		.HOST_INTERRUPT_OE_N(int_oe_n), .HOST_PORT_ENABLE_STRAP(strap), .PADS(pads),
		.TEST_PINS(tst), .OUTPUTS_OFF(off), .CORE_READY(core_rdy), .CORE_INTERRUPT(core_int),
		.CORE_RD_EN(rd_en), .CORE_RD_DATA(8'hA5), .HOLDER_SW_EN(hold),
		.PORT_SELECTED(sel), .ACCESS_STB(stb), .ACCESS(acc), .WR_DATA(wd)
	);
	host_model i_host (.CLK(clk), .CTL(ctl), .DQ(dq_i));

	always #20 clk = ~clk;
	always @(negedge clk) begin
		if (stb === 1'h1) pulses++;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 400) begin
			fails++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wrap_up();
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		// Asserted after time zero so the reset edge is seen
		#1 arst_n = 1'h0;
		wait_n(4);
		chk("intr", 8'h01, 8'(int_n));
		chk("pulldown", 8'h01, 8'(pads.strap_pulldown_en));
		arst_n = 1'h1;
		wait_n(3);
		chk("selected", 8'h01, 8'(sel));
		chk("pulldown", 8'h00, 8'(pads.strap_pulldown_en));
		chk("pullup", 8'h00, 8'(pads.pullup_en));
		chk("holder", 8'h00, 8'(pads.data_hold_en));
		chk("ready", 8'h00, 8'(rdy));
		strap = 1'h0;
		hold = 1'h1;
		wait_n(4);
		chk("selected", 8'h01, 8'(sel));
		chk("holder", 8'h01, 8'(pads.data_hold_en));
		core_rdy = 1'h1;
		core_int = 1'h1;
		wait_n(2);
		chk("ready", 8'h01, 8'(rdy));
		chk("intr", 8'h00, 8'(int_n));
		rd_en = 1'h1;
		foreach (rows[i]) begin
			tst = test_cond_s'(rows[i][3:1]);
			wait_n(5);
			chk("off", 8'(rows[i][0]), 8'(off));
			chk("ready oe", 8'(rows[i][0]), 8'(rdy_oe_n));
			chk("intr oe", 8'(rows[i][0]), 8'(int_oe_n));
			chk("data oe", 8'(rows[i][0]), 8'(dq_oe_n));
		end
		chk("data", 8'hA5, dq_o);
		rd_en = 1'h0;
		wait_n(2);
		chk("data oe", 8'h01, 8'(dq_oe_n));
		i_host.access(1'h1, 1'h1, 8'h3C);
		chk("pulses", 8'h01, 8'(pulses));
		chk("write", 8'h01, 8'(acc.write));
		chk("byte ident", 8'h01, 8'(acc.byte_ident));
		chk("ctrl", 8'h02, 8'(acc.ctrl));
		chk("wr data", 8'h3C, wd);
		i_host.access(1'h0, 1'h0, 8'hC3);
		chk("pulses", 8'h02, 8'(pulses));
		chk("write", 8'h00, 8'(acc.write));
		chk("byte ident", 8'h00, 8'(acc.byte_ident));
		chk("wr data", 8'hC3, wd);
		arst_n = 1'h0;
		hold = 1'h0;
		wait_n(4);
		arst_n = 1'h1;
		core_int = 1'h1;
		rd_en = 1'h1;
		wait_n(3);
		chk("selected", 8'h00, 8'(sel));
		chk("pads", 8'h06, 8'(pads));
		chk("intr", 8'h01, 8'(int_n));
		chk("data oe", 8'h01, 8'(dq_oe_n));
		i_host.access(1'h1, 1'h1, 8'h5A);
		wait_n(3);
		chk("pulses", 8'h02, 8'(pulses));
		wrap_up();
	end
endmodule
